/* File: rtl/rxrm_ring_manager.v */
// Functional notes
// - reaching the read limit page while linking aborts the packet in progress.
// - a ring overflow sets the overflow warning flag in interrupt status.
// - after overflow local receive stays suspended until software halts the block.
// - the missed packet tally never counts while the block is halted.
// - a start with loopback selected keeps local receive inactive.
// - an accepted packet gets status, next pointer and count at its first page.
// - the next packet starts on the next empty page boundary.
// - after the header the write page pointer takes the precomputed next page.
// - rejected packets rewind to the write page pointer unless acceptance is set.
// - the frame check bytes are stored right after the last data byte.
// - word mode puts status low, pointer high; byte order swaps count and data.
// - byte mode stores status, pointer, count low, count high, then data.
// - four bytes at the start of the first page are kept for the header.
// - the page after the last ring page is the ring's first page.
`timescale 1ns/1ps
`default_nettype none
`include "rxrm_defines.vh"

module rxrm_ring_manager (
  // clock and reset
  input  wire        ref_clk,
  input  wire        resetn,
  // register port
  input  wire [3:0]  regAddr,
  input  wire [7:0]  regWdata,
  input  wire        regWrite,
  input  wire        regRead,
  output reg  [7:0]  regRdata,
  // receive byte stream
  input  wire        rxValid,
  input  wire [7:0]  rxData,
  input  wire        rxLast,
  input  wire        rxRunt,
  input  wire        rxCrcErr,
  input  wire        rxAlignErr,
  // buffer memory write port
  output reg         memWe,
  output reg  [15:0] memAddr,
  output reg  [15:0] memWdata,
  output reg  [1:0]  memLaneEn,
  // status
  output reg         rxDmaActive
);

  // ----------------------------------------
  // states
  // ----------------------------------------
  localparam [3:0] ST_IDLE = 4'b0001;
  localparam [3:0] ST_RECV = 4'b0010;
  localparam [3:0] ST_DROP = 4'b0100;
  localparam [3:0] ST_HDR  = 4'b1000;

  // ----------------------------------------
  // registers
  // ----------------------------------------
  reg [3:0]  state;
  reg [7:0]  commandReg;
  reg [7:0]  ringFirstPage;
  reg [7:0]  ringEndPage;
  reg [7:0]  readLimitPointer;
  reg [7:0]  writePagePointer;
  reg [7:0]  interruptStatus;
  reg [7:0]  dataConfigReg;
  reg [7:0]  rxConfigReg;
  reg [7:0]  txConfigReg;
  reg [7:0]  missedTally;
  reg [7:0]  remoteCountLow;
  reg [7:0]  remoteCountHigh;
  reg        overflowSuspend;
  reg [15:0] dmaAddr;
  reg [15:0] byteCount;
  reg [7:0]  heldByte;
  reg [7:0]  scratchPage;
  reg [7:0]  rxStatusByte;
  reg [1:0]  hdrIdx;

  // ----------------------------------------
  // combinational helpers
  // ----------------------------------------
  wire        haltBit     = commandReg[`RXRM_CMD_HALT];
  wire        startBit    = commandReg[`RXRM_CMD_START];
  wire        wordMode    = dataConfigReg[`RXRM_DCFG_WORD];
  wire        byteOrder   = dataConfigReg[`RXRM_DCFG_ORDER];
  wire        loopbackSel = txConfigReg[`RXRM_TCFG_LB_HI] | txConfigReg[`RXRM_TCFG_LB_LO];
  // loopback keeps the local receive channel idle even after a start command
  wire        dmaEnable   = startBit & ~haltBit & ~loopbackSel & ~overflowSuspend;
  wire        inIdle      = (state == ST_IDLE);
  wire        takeByte    = rxValid & ((inIdle & dmaEnable) | (state == ST_RECV));
  // the first byte of a packet lands behind the space reserved for the header
  wire [15:0] curAddr     = inIdle ? {writePagePointer, `RXRM_HDR_OFFSET} : dmaAddr;
  wire        pageEdge    = (curAddr[7:0] == `RXRM_PAGE_LAST);
  wire [7:0]  stepPage;
  wire        hitLimit    = takeByte & pageEdge & (stepPage == readLimitPointer);
  wire        badFrame    = (rxRunt & ~rxConfigReg[`RXRM_RCFG_ACCRUNT]) |
                            ((rxCrcErr | rxAlignErr) & ~rxConfigReg[`RXRM_RCFG_ACCERR]);
  wire [15:0] countNow    = inIdle ? 16'h0001 : byteCount + 16'h0001;
  wire        hdrDone     = wordMode ? (hdrIdx == 2'h1) : (hdrIdx == 2'h3);
  wire        wrHit       = regWrite;
  wire        missedInc;
  wire        rxOkSet;
  wire        rxErrSet;

  rxrm_page_step stepU (
    .page      (curAddr[15:8]),
    .firstPage (ringFirstPage),
    .endPage   (ringEndPage),
    .nextPage  (stepPage)
  );

  // a packet is missed when it starts while the channel is suspended, or when it
  // overruns the ring; nothing is tallied while halted
  assign missedInc = ~haltBit & ((rxValid & inIdle & startBit & overflowSuspend) | hitLimit);
  assign rxOkSet   = (state == ST_HDR) & hdrDone;
  assign rxErrSet  = takeByte & rxLast & ~hitLimit & badFrame;

  // places the even-address byte in its lane; byte order puts it high
  function [15:0] laneData;
    input [7:0] evenByte;
    input [7:0] oddByte;
    input       swapOrder;
    begin
      laneData = swapOrder ? {evenByte, oddByte} : {oddByte, evenByte};
    end
  endfunction

  // ----------------------------------------
  // next values of the host-visible registers
  // ----------------------------------------
  reg [7:0] next_interruptStatus;
  reg [7:0] next_missedTally;

  always @* begin
    next_interruptStatus = interruptStatus;
    // write-one-to-clear; a same-cycle event still lands because sets come last
    if (wrHit && regAddr == `RXRM_REG_ISTAT) begin
      next_interruptStatus = interruptStatus & ~regWdata;
    end
    if (hitLimit) begin
      next_interruptStatus[`RXRM_IST_OVFL] = 1'b1;
    end
    if (rxOkSet) begin
      next_interruptStatus[`RXRM_IST_RXOK] = 1'b1;
    end
    if (rxErrSet) begin
      next_interruptStatus[`RXRM_IST_RXERR] = 1'b1;
    end
    next_missedTally = missedTally;
    if (regRead && regAddr == `RXRM_REG_MISSED) begin
      next_missedTally = 8'h00;
    end
    // saturates rather than wrapping so a flood never reads as few misses
    if (missedInc && next_missedTally != `RXRM_MISSED_MAX) begin
      next_missedTally = next_missedTally + 8'h01;
    end
  end

  // ----------------------------------------
  // register file, receive engine and memory port
  // ----------------------------------------
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      state            <= ST_IDLE;
      commandReg       <= `RXRM_CMD_RESET;
      ringFirstPage    <= `RXRM_FIRST_RESET;
      ringEndPage      <= `RXRM_END_RESET;
      readLimitPointer <= `RXRM_LIMIT_RESET;
      writePagePointer <= `RXRM_WRPTR_RESET;
      interruptStatus  <= 8'h00;
      dataConfigReg    <= 8'h00;
      rxConfigReg      <= 8'h00;
      txConfigReg      <= 8'h00;
      missedTally      <= 8'h00;
      remoteCountLow   <= 8'h00;
      remoteCountHigh  <= 8'h00;
      overflowSuspend  <= 1'b0;
      dmaAddr          <= 16'h0000;
      byteCount        <= 16'h0000;
      heldByte         <= 8'h00;
      scratchPage      <= 8'h00;
      rxStatusByte     <= 8'h00;
      hdrIdx           <= 2'h0;
      regRdata         <= 8'h00;
      memWe            <= 1'b0;
      memAddr          <= 16'h0000;
      memWdata         <= 16'h0000;
      memLaneEn        <= 2'h0;
      rxDmaActive      <= 1'b0;
    end else begin
      interruptStatus <= next_interruptStatus;
      missedTally     <= next_missedTally;
      rxDmaActive     <= dmaEnable;
      memWe           <= 1'b0;
      memLaneEn       <= 2'h0;

      // host writes
      if (wrHit) begin
        if (regAddr == `RXRM_REG_CMD) begin
          commandReg <= regWdata;
          // halting is the start of recovery and lifts the overflow suspension
          if (regWdata[`RXRM_CMD_HALT]) begin
            overflowSuspend <= 1'b0;
          end
        end else if (regAddr == `RXRM_REG_FIRST) begin
          ringFirstPage <= regWdata;
        end else if (regAddr == `RXRM_REG_END) begin
          ringEndPage <= regWdata;
        end else if (regAddr == `RXRM_REG_LIMIT) begin
          readLimitPointer <= regWdata;
        end else if (regAddr == `RXRM_REG_WRPTR) begin
          writePagePointer <= regWdata;
        end else if (regAddr == `RXRM_REG_DCFG) begin
          dataConfigReg <= regWdata;
        end else if (regAddr == `RXRM_REG_RCFG) begin
          rxConfigReg <= regWdata;
        end else if (regAddr == `RXRM_REG_TCFG) begin
          txConfigReg <= regWdata;
        end else if (regAddr == `RXRM_REG_RCNTLO) begin
          remoteCountLow <= regWdata;
        end else if (regAddr == `RXRM_REG_RCNTHI) begin
          remoteCountHigh <= regWdata;
        end
      end

      // host reads, data valid in the following cycle only
      regRdata <= 8'h00;
      if (regRead) begin
        if (regAddr == `RXRM_REG_CMD) begin
          regRdata <= commandReg;
        end else if (regAddr == `RXRM_REG_FIRST) begin
          regRdata <= ringFirstPage;
        end else if (regAddr == `RXRM_REG_END) begin
          regRdata <= ringEndPage;
        end else if (regAddr == `RXRM_REG_LIMIT) begin
          regRdata <= readLimitPointer;
        end else if (regAddr == `RXRM_REG_WRPTR) begin
          regRdata <= writePagePointer;
        end else if (regAddr == `RXRM_REG_ISTAT) begin
          regRdata <= interruptStatus;
        end else if (regAddr == `RXRM_REG_DCFG) begin
          regRdata <= dataConfigReg;
        end else if (regAddr == `RXRM_REG_RCFG) begin
          regRdata <= rxConfigReg;
        end else if (regAddr == `RXRM_REG_TCFG) begin
          regRdata <= txConfigReg;
        end else if (regAddr == `RXRM_REG_MISSED) begin
          regRdata <= missedTally;
        end else if (regAddr == `RXRM_REG_RCNTLO) begin
          regRdata <= remoteCountLow;
        end else if (regAddr == `RXRM_REG_RCNTHI) begin
          regRdata <= remoteCountHigh;
        end else if (regAddr == `RXRM_REG_STATE) begin
          regRdata <= {overflowSuspend, dmaEnable, 2'b00, state};
        end
      end

      // store one received byte, frame check bytes included as plain data
      if (takeByte) begin
        byteCount <= countNow;
        if (!wordMode) begin
          memWe     <= 1'b1;
          memAddr   <= curAddr;
          memWdata  <= {8'h00, rxData};
          memLaneEn <= 2'b01;
        end else if (!curAddr[0]) begin
          heldByte <= rxData;
          // an odd byte count leaves a lone even byte to flush on its own
          if (rxLast) begin
            memWe     <= 1'b1;
            memAddr   <= {curAddr[15:1], 1'b0};
            memWdata  <= laneData(rxData, 8'h00, byteOrder);
            memLaneEn <= byteOrder ? 2'b10 : 2'b01;
          end
        end else begin
          memWe     <= 1'b1;
          memAddr   <= {curAddr[15:1], 1'b0};
          memWdata  <= laneData(heldByte, rxData, byteOrder);
          memLaneEn <= 2'b11;
        end
        // link to the following page at a page edge, even when that page is the read limit
        if (pageEdge) begin
          dmaAddr <= {stepPage, 8'h00};
        end else begin
          dmaAddr <= curAddr + 16'h0001;
        end
      end

      case (state)
        ST_IDLE: begin
          if (rxValid) begin
            if (hitLimit) begin
              overflowSuspend <= 1'b1;
              state           <= rxLast ? ST_IDLE : ST_DROP;
            end else if (dmaEnable) begin
              if (rxLast) begin
                state <= badFrame ? ST_IDLE : ST_HDR;
              end else begin
                state <= ST_RECV;
              end
            end else if (!rxLast) begin
              state <= ST_DROP;
            end
          end
        end
        ST_RECV: begin
          if (rxValid) begin
            if (hitLimit) begin
              // earlier packets in the ring stay untouched; this one is lost
              overflowSuspend <= 1'b1;
              state           <= rxLast ? ST_IDLE : ST_DROP;
            end else if (rxLast) begin
              // rejection leaves the write page pointer alone, so its pages are reused
              state <= badFrame ? ST_IDLE : ST_HDR;
            end
          end
        end
        ST_DROP: begin
          if (rxValid && rxLast) begin
            state <= ST_IDLE;
          end
        end
        ST_HDR: begin
          hdrIdx <= hdrIdx + 2'h1;
          memWe  <= 1'b1;
          if (wordMode) begin
            memLaneEn <= 2'b11;
            memAddr   <= {writePagePointer, 6'h00, hdrIdx[0], 1'b0};
            if (hdrIdx[0] == 1'b0) begin
              memWdata <= {scratchPage, rxStatusByte};
            end else begin
              memWdata <= laneData(byteCount[7:0], byteCount[15:8], byteOrder);
            end
          end else begin
            memLaneEn <= 2'b01;
            memAddr   <= {writePagePointer, 6'h00, hdrIdx};
            if (hdrIdx == 2'h0) begin
              memWdata <= {8'h00, rxStatusByte};
            end else if (hdrIdx == 2'h1) begin
              memWdata <= {8'h00, scratchPage};
            end else if (hdrIdx == 2'h2) begin
              memWdata <= {8'h00, byteCount[7:0]};
            end else begin
              memWdata <= {8'h00, byteCount[15:8]};
            end
          end
          if (hdrDone) begin
            hdrIdx           <= 2'h0;
            writePagePointer <= scratchPage;
            state            <= ST_IDLE;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase

      // end of an accepted frame: remember where the next one will begin
      if (takeByte && rxLast && !hitLimit && !badFrame) begin
        scratchPage  <= stepPage;
        hdrIdx       <= 2'h0;
        rxStatusByte <= {4'h0, rxRunt, rxAlignErr, rxCrcErr, 1'b1};
      end
    end
  end

endmodule

`default_nettype wire

/* File: rtl/rxrm_defines.vh */
`ifndef RXRM_DEFINES_VH
`define RXRM_DEFINES_VH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define RXRM_REG_CMD      4'h0
`define RXRM_REG_FIRST    4'h1
`define RXRM_REG_END      4'h2
`define RXRM_REG_LIMIT    4'h3
`define RXRM_REG_WRPTR    4'h4
`define RXRM_REG_ISTAT    4'h5
`define RXRM_REG_DCFG     4'h6
`define RXRM_REG_RCFG     4'h7
`define RXRM_REG_TCFG     4'h8
`define RXRM_REG_MISSED   4'h9
`define RXRM_REG_RCNTLO   4'ha
`define RXRM_REG_RCNTHI   4'hb
`define RXRM_REG_STATE    4'hc

// ----------------------------------------
// field positions
// ----------------------------------------
`define RXRM_CMD_HALT     0
`define RXRM_CMD_START    1
`define RXRM_CMD_TXREQ    2
`define RXRM_DCFG_WORD    0
`define RXRM_DCFG_ORDER   1
`define RXRM_RCFG_ACCERR  0
`define RXRM_RCFG_ACCRUNT 1
`define RXRM_TCFG_LB_LO   1
`define RXRM_TCFG_LB_HI   2
`define RXRM_IST_RXOK     0
`define RXRM_IST_RXERR    2
`define RXRM_IST_OVFL     4
`define RXRM_RST_OK       0
`define RXRM_RST_CRC      1
`define RXRM_RST_ALIGN    2
`define RXRM_RST_RUNT     3

// ----------------------------------------
// reset values and layout constants
// ----------------------------------------
`define RXRM_CMD_RESET    8'h21
`define RXRM_FIRST_RESET  8'h40
`define RXRM_END_RESET    8'h80
`define RXRM_LIMIT_RESET  8'h40
`define RXRM_WRPTR_RESET  8'h40
`define RXRM_HDR_OFFSET   8'h04
`define RXRM_PAGE_LAST    8'hff
`define RXRM_MISSED_MAX   8'hff

`endif

/* File: rtl/rxrm_page_step.v */
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------
// next 256-byte page of the ring
// ----------------------------------------
module rxrm_page_step (
  // current page and ring bounds
  input  wire [7:0] page,
  input  wire [7:0] firstPage,
  input  wire [7:0] endPage,
  // following page
  output wire [7:0] nextPage
);

  wire [7:0] plainNext;

  assign plainNext = page + 8'h01;
  // the end page itself is never used, the ring folds back onto the first page
  assign nextPage  = (plainNext == endPage) ? firstPage : plainNext;

endmodule

`default_nettype wire

/* File: test/rxrm_mem_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ------------------------------
// shared buffer memory, byte image
// ------------------------------
module rxrm_mem_model (
  // clock
  input wire logic        ref_clk,
  // write port
  input wire logic        memWe,
  input wire logic [15:0] memAddr,
  input wire logic [15:0] memWdata,
  input wire logic [1:0]  memLaneEn
);
  // never-written bytes stay unknown so a missing write cannot match
  logic [7:0] mem [0:65535];
  always @(posedge ref_clk) begin
    if (memWe && memLaneEn[0]) mem[memAddr] <= memWdata[7:0];
    if (memWe && memLaneEn[1]) mem[memAddr | 16'h0001] <= memWdata[15:8];
  end
endmodule
`default_nettype wire

/* File: test/rxrm_props.sv */
`timescale 1ns/1ps
`default_nettype none
module rxrm_props (
  // clock and reset
  input wire logic        ref_clk,
  input wire logic        resetn,
  // register port
  input wire logic [3:0]  regAddr,
  input wire logic [7:0]  regWdata,
  input wire logic        regWrite,
  input wire logic        regRead,
  input wire logic [7:0]  regRdata,
  // receive stream
  input wire logic        rxValid,
  input wire logic [7:0]  rxData,
  input wire logic        rxLast,
  input wire logic        rxRunt,
  input wire logic        rxCrcErr,
  input wire logic        rxAlignErr,
  // memory and status
  input wire logic        memWe,
  input wire logic [15:0] memAddr,
  input wire logic [15:0] memWdata,
  input wire logic [1:0]  memLaneEn,
  input wire logic        rxDmaActive
);
  logic       wordSel, haltSel, lbSel, accErr, ovSeen;
  logic [7:0] firstPg, endPg, limPg;
  wire  [7:0] pgInc = memAddr[15:8] + 8'h01;
  wire  [7:0] nxt   = (pgInc == endPg) ? firstPg : pgInc;
  wire        atEnd = memWe && !wordSel && memAddr[7:0] == 8'hff;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  // ------------------------------
  // register shadows from host writes
  // ------------------------------
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      {wordSel, haltSel, lbSel, accErr, ovSeen} <= 5'h08;
      {firstPg, endPg, limPg} <= 24'h408040;
    end else begin
      if (regWrite && regAddr == 4'h0) haltSel <= regWdata[0];
      if (regWrite && regAddr == 4'h6) wordSel <= regWdata[0];
      if (regWrite && regAddr == 4'h7) accErr <= regWdata[0];
      if (regWrite && regAddr == 4'h8) lbSel <= |regWdata[2:1];
      if (regWrite && regAddr == 4'h1) firstPg <= regWdata;
      if (regWrite && regAddr == 4'h2) endPg <= regWdata;
      if (regWrite && regAddr == 4'h3) limPg <= regWdata;
      // set wins over a clear in the same cycle
      if (atEnd && nxt == limPg && !$past(rxLast)) ovSeen <= 1'b1;
      else if (regWrite && regAddr == 4'h5 && regWdata[4]) ovSeen <= 1'b0;
    end
  end
  // ------------------------------
  // properties
  // ------------------------------
  chk_rd_idle: assert property (!regRead |=> regRdata == 8'h00)
    else $error("read data not idle");
  chk_gate_off: assert property ((haltSel || lbSel) && $past(haltSel || lbSel)
    |-> !rxDmaActive) else $error("receive active while halted or looped");
  chk_byte_store: assert property (rxValid && rxDmaActive && !wordSel && !atEnd
    |=> memWe && memWdata == {8'h00, $past(rxData)}) else $error("byte not stored");
  chk_hdr_order: assert property (rxValid && rxLast && rxDmaActive && !wordSel
    && !(rxRunt || rxCrcErr || rxAlignErr) |=> ##1 memWe && memAddr[7:0] == 8'h00
    ##1 memWe && memAddr[7:0] == 8'h01 ##1 memWe && memAddr[7:0] == 8'h02
    ##1 memWe && memAddr[7:0] == 8'h03) else $error("header order wrong");
  chk_reject: assert property (rxValid && rxLast && rxDmaActive && !accErr
    && (rxCrcErr || rxAlignErr) |=> ##1 !memWe [*4]) else $error("rejected frame written");
  chk_ovfl_abort: assert property (atEnd && nxt == limPg && !$past(rxLast)
    |-> ##2 (!memWe && !rxDmaActive) [*3]) else $error("overflow not aborted");
  chk_link_page: assert property (atEnd && nxt != limPg && !$past(rxLast)
    |=> memWe && memAddr == {$past(nxt), 8'h00}) else $error("page link wrong");
  chk_ovfl_flag: assert property (regRead && regAddr == 4'h5 && ovSeen |=> regRdata[4])
    else $error("overflow flag missing");
  cov_hdr: cover property (memWe && memAddr[7:0] == 8'h03);
  cov_ovfl: cover property (ovSeen);
  cov_link: cover property (atEnd && !rxLast);
endmodule
`default_nettype wire

/* File: test/test_rx_buffer_ring_manager.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin nTests++; if ((a) !== (e)) begin badCount++; \
  $display("FAIL t=%0t got %h exp %h", $time, a, e); end end
`define M(x) rxrm_mem_model_i.mem[x]
`define PINS .ref_clk(ref_clk), .resetn(resetn), .regAddr(regAddr), .regWdata(regWdata), \
  .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata), .rxValid(rxValid), \
  .rxData(rxData), .rxLast(rxLast), .rxRunt(rxRunt), .rxCrcErr(rxCrcErr), \
  .rxAlignErr(rxAlignErr), .memWe(memWe), .memAddr(memAddr), .memWdata(memWdata), \
  .memLaneEn(memLaneEn), .rxDmaActive(rxDmaActive)
module test_rx_buffer_ring_manager;
  logic        ref_clk, resetn, regWrite, regRead, rxValid, rxLast, rxRunt, rxCrcErr;
  logic        rxAlignErr, tx;
  logic [3:0]  regAddr;
  logic [7:0]  regWdata, rxData, d, seed;
  wire  [7:0]  regRdata;
  wire  [15:0] memAddr, memWdata;
  wire  [1:0]  memLaneEn;
  wire         memWe, rxDmaActive;
  logic [7:0]  q[$];
  int          badCount, nTests, wp, nx, ep;
  int          lens[3] = '{60, 252, 253};
  logic [2:0]  errs[3] = '{3'h4, 3'h2, 3'h1};
  logic [7:0]  dcf[2] = '{8'h01, 8'h03};
  logic [7:0]  rv[5] = '{8'h21, 8'h40, 8'h80, 8'h40, 8'h40};
  rxrm_ring_manager rxrm_ring_manager_i (`PINS);
  rxrm_mem_model rxrm_mem_model_i (.ref_clk(ref_clk), .memWe(memWe), .memAddr(memAddr),
    .memWdata(memWdata), .memLaneEn(memLaneEn));
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  // ------------------------------
  // helpers and bench model
  // ------------------------------
  task wrapUp();
    if (badCount == 0 && nTests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  // ring page after n pages, wrapping at the end page
  function automatic int nextp(input int p, input int n, input int e);
    for (int i = 0; i < n; i++) p = (p + 1 == e) ? 64 : p + 1;
    return p;
  endfunction
  task idle(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge ref_clk);
    regAddr <= a;
    regWdata <= v;
    regWrite <= 1'b1;
    @(posedge ref_clk);
    regWrite <= 1'b0;
  endtask
  task rd(input logic [3:0] a, output logic [7:0] v);
    @(posedge ref_clk);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge ref_clk);
    regRead <= 1'b0;
    #1 v = regRdata;
  endtask
  // gap after the frame leaves room for the header writes
  task sendF(input int n, input logic [2:0] e);
    q.delete();
    for (int i = 0; i < n; i++) begin
      @(posedge ref_clk);
      seed = lfsr(seed);
      q.push_back(seed);
      rxValid <= 1'b1;
      rxData <= seed;
      rxLast <= (i == n - 1);
      {rxRunt, rxCrcErr, rxAlignErr} <= e;
    end
    @(posedge ref_clk);
    rxValid <= 1'b0;
    rxLast <= 1'b0;
    idle(8);
  endtask
  task chkFrame(input int p, input int x, input int sw, input logic [7:0] st);
    int a;
    a = p * 256;
    `CHK(`M(a), st)
    `CHK(`M(a + 1), 8'(x))
    `CHK(`M(a + 2 + sw), 8'(q.size()))
    `CHK(`M(a + 3 - sw), 8'(q.size() >> 8))
    foreach (q[k]) `CHK(`M(a + 4 + (k ^ sw)), q[k])
  endtask
  initial begin
    #4000000;
    badCount++;
    wrapUp();
  end
  // ------------------------------
  // main sequence
  // ------------------------------
  initial begin
    {resetn, regWrite, regRead, rxValid, rxLast, rxRunt, rxCrcErr, rxAlignErr} = '0;
    {regAddr, regWdata, rxData} = '0;
    seed = 8'h4e;
    ep = 128;
    idle(8);
    resetn = 1'b1;
    for (int i = 0; i < 5; i++) begin
      rd(4'(i), d);
      `CHK(d, rv[i])
    end
    rd(4'hf, d);
    `CHK(d, 8'h00)
    wr(4'h0, 8'h21);
    wr(4'ha, 8'h00);
    wr(4'hb, 8'h00);
    wr(4'h8, 8'h04);
    wr(4'h5, 8'hff);
    wr(4'h0, 8'h61);
    wr(4'h4, 8'h40);
    wr(4'h0, 8'h22);
    idle(3);
    `CHK(rxDmaActive, 1'b0)
    wr(4'h8, 8'h00);
    idle(3);
    `CHK(rxDmaActive, 1'b1)
    wp = 64;
    foreach (lens[i]) begin
      sendF(lens[i], 3'h0);
      nx = nextp(wp, (lens[i] + 259) / 256, ep);
      chkFrame(wp, nx, 0, 8'h01);
      rd(4'h4, d);
      `CHK(d, 8'(nx))
      wp = nx;
    end
    rd(4'h5, d);
    `CHK(d[0], 1'b1)
    foreach (errs[i]) begin
      sendF(20, errs[i]);
      rd(4'h4, d);
      `CHK(d, 8'(wp))
    end
    rd(4'h5, d);
    `CHK(d[2], 1'b1)
    wr(4'h7, 8'h03);
    sendF(20, 3'h2);
    nx = nextp(wp, 1, ep);
    chkFrame(wp, nx, 0, 8'h03);
    wp = nx;
    wr(4'h7, 8'h00);
    foreach (dcf[i]) begin
      wr(4'h6, dcf[i]);
      sendF(61, 3'h0);
      nx = nextp(wp, 1, ep);
      chkFrame(wp, nx, dcf[i][1], 8'h01);
      wp = nx;
    end
    wr(4'h6, 8'h00);
    ep = wp + 1;
    wr(4'h2, 8'(ep));
    sendF(10, 3'h0);
    chkFrame(wp, nextp(wp, 1, ep), 0, 8'h01);
    wp = 64;
    ep = 128;
    wr(4'h2, 8'h80);
    wr(4'h3, 8'(wp + 1));
    sendF(300, 3'h0);
    `CHK(`M(wp * 256 + 255), q[251])
    `CHK(rxDmaActive, 1'b0)
    rd(4'h5, d);
    `CHK(d[4], 1'b1)
    sendF(10, 3'h0);
    rd(4'h9, d);
    `CHK(d, 8'h02)
    rd(4'h0, d);
    tx = d[2];
    wr(4'h0, 8'h21);
    sendF(10, 3'h0);
    idle(16000);
    rd(4'h9, d);
    `CHK(d, 8'h00)
    wr(4'ha, 8'h00);
    wr(4'hb, 8'h00);
    wr(4'h8, 8'h02);
    wr(4'h0, 8'h22);
    wr(4'h3, 8'h60);
    wr(4'h5, 8'h10);
    rd(4'h5, d);
    `CHK(d[4], 1'b0)
    wr(4'h8, 8'h00);
    if (tx) wr(4'h0, 8'h26);
    idle(3);
    `CHK(rxDmaActive, 1'b1)
    sendF(20, 3'h0);
    chkFrame(wp, nextp(wp, 1, ep), 0, 8'h01);
    wrapUp();
  end
endmodule
bind rxrm_ring_manager rxrm_props rxrm_props_i (`PINS);
`default_nettype wire
